// ### verif/fcr_top_assertions.sv
// Checker: bus writes against command outputs of the flash block
`timescale 1ns/1ps
module fcr_top_assertions (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire fcr_pkg::fcr_req_t req_i,
    input  wire logic [7:0]        rdata_o,
    input  wire logic              rvalid_o,
    input  wire fcr_pkg::fcr_cmd_t cmd_o
);
    // Write strobes and decoded fields
    wire       wr_ctl = req_i.wr && req_i.addr == fcr_pkg::FCR_ADDR_CTRL;
    wire       wr_key = req_i.wr && req_i.addr == fcr_pkg::FCR_ADDR_KEY;
    wire [3:0] code   = req_i.wdata[7:4];
    wire [1:0] op     = cmd_o.op;
    // Accepted start: erase or lock stored, key open
    wire       go     = wr_ctl && req_i.wdata[0] && op[1] && cmd_o.unlocked;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_PROG: assert property (wr_ctl && code == 4'h5 |=> op == 2'h1)
        else $error("Program mode not selected");
    AST_ERAS: assert property (wr_ctl && code == 4'hA |=> op == 2'h2)
        else $error("Erase mode not selected");
    AST_LOCK: assert property (wr_ctl && code == 4'h6 |=> op == 2'h3)
        else $error("Hard lock mode not selected");
    AST_NONE: assert property (
        wr_ctl && !(code inside {4'h5, 4'hA, 4'h6}) |=> op == 2'h0)
        else $error("Unused code selected an operation");
    AST_SECH: assert property (
        req_i.wr && req_i.addr == 8'hEC |=> cmd_o.sector[15:8] ==
        $past(req_i.wdata)) else $error("Sector high byte wrong");
    AST_SECL: assert property (
        req_i.wr && req_i.addr == 8'hED |=> cmd_o.sector[7:0] ==
        $past(req_i.wdata)) else $error("Sector low byte wrong");
    AST_KEY: assert property (
        wr_key |=> cmd_o.unlocked == ($past(req_i.wdata) == 8'hA5))
        else $error("Unlock state wrong");
    AST_START: assert property (go |=> cmd_o.start)
        else $error("Start not launched");
    AST_GATE: assert property (cmd_o.start |-> $past(go))
        else $error("Start without accepted request");
    AST_RVAL: assert property (rvalid_o == $past(req_i.rd))
        else $error("Read answer strobe wrong");
    cover property (go);
    cover property (wr_key ##1 !cmd_o.unlocked);
    cover property (rvalid_o);
endmodule
bind fcr_top fcr_top_assertions fcr_top_assertions_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cmd_o(cmd_o));

// ### verif/fcr_top_tb_top.sv
// Testbench: mode rows, unlock, start and sector checks of the flash block
`timescale 1ns/1ps
module fcr_top_tb_top;
    logic              clk_i      = 1'b0;
    logic              rst_n_i    = 1'b0;
    fcr_pkg::fcr_req_t req_i      = '0;
    logic [7:0]        rdata_o;
    logic              rvalid_o;
    fcr_pkg::fcr_cmd_t cmd_o;
    int                err_count  = 0;
    int                num_checks = 0;
    // Rows: control byte written, operation expected
    logic [9:0]        rows [5]   = '{{8'h50, 2'h1}, {8'hAE, 2'h2},
                                      {8'h60, 2'h3}, {8'hF1, 2'h0},
                                      {8'h00, 2'h0}};
    fcr_top fcr_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cmd_o(cmd_o));
    // Clock, 100 ns period
    always #50 clk_i = ~clk_i;
    // Compare and count
    task automatic check(input string n, input logic [19:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus cycle: kind 2 write, 1 read
    task automatic bus(input logic [1:0] k, input logic [7:0] a, d);
        @(negedge clk_i);
        req_i = {k, a, d};
        @(negedge clk_i);
        req_i = '0;
    endtask
    // Counts and verdict
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        check("cmd_rst", cmd_o, 20'h0);
        // Locked: every mode row, start bit has no effect
        foreach (rows[i]) begin
            bus(2'h2, 8'hEF, rows[i][9:2]);
            check("op", cmd_o.op, rows[i][1:0]);
            check("start", cmd_o.start, 20'h0);
            bus(2'h1, 8'hEF, 8'h00);
            check("ctl_rd", rdata_o, rows[i][9:2] & 8'hF0);
        end
        bus(2'h2, 8'hEE, 8'hA5);
        check("unl", cmd_o.unlocked, 20'h1);
        // Start under program mode is ignored
        bus(2'h2, 8'hEF, 8'h51);
        bus(2'h2, 8'hEF, 8'h51);
        check("st_prog", cmd_o.start, 20'h0);
        // Erase then hard lock start, erase start checked to self-clear
        bus(2'h2, 8'hEF, 8'hA0);
        bus(2'h2, 8'hEF, 8'hA1);
        check("st_era", cmd_o.start, 20'h1);
        @(negedge clk_i);
        check("st_clr", cmd_o.start, 20'h0);
        bus(2'h2, 8'hEF, 8'h60);
        bus(2'h2, 8'hEF, 8'h61);
        check("st_lock", cmd_o.start, 20'h1);
        // Relock with another key, start refused
        bus(2'h2, 8'hEE, 8'hA4);
        check("lock", cmd_o.unlocked, 20'h0);
        bus(2'h2, 8'hEF, 8'h61);
        check("st_lk", cmd_o.start, 20'h0);
        bus(2'h2, 8'hEC, 8'h12);
        bus(2'h2, 8'hED, 8'h34);
        check("sector", cmd_o.sector, 20'h1234);
        bus(2'h1, 8'hEC, 8'h00);
        check("rvalid", rvalid_o, 20'h1);
        check("sech_rd", rdata_o, 20'h12);
        // Unmapped read gives zero
        bus(2'h1, 8'hEB, 8'h00);
        check("unmap", rdata_o, 20'h0);
        // Read answer stands one cycle only
        @(negedge clk_i);
        check("rv_drop", rvalid_o, 20'h0);
        // Unmapped write leaves every register alone
        bus(2'h2, 8'hEB, 8'hFF);
        check("unmap_wr", cmd_o, 20'hC1234);
        // Mid-run reset clears every register
        bus(2'h1, 8'hEC, 8'h00);
        bus(2'h2, 8'hEE, 8'hA5);
        rst_n_i = 1'h0;
        #1;
        check("cmd_mid", cmd_o, 20'h0);
        check("rd_mid", {rvalid_o, rdata_o}, 20'h0);
        @(negedge clk_i);
        rst_n_i = 1'h1;
        bus(2'h1, 8'hEE, 8'h00);
        check("key_rst", rdata_o, 20'h0);
        conclude();
    end
endmodule

// ### verilog/fcr_byte_reg.sv
// One 8-bit read/write register with address match
`timescale 1ns/1ps
module fcr_byte_reg #(
    parameter logic [7:0] ADDR  = 8'h00,
    parameter logic [7:0] RESET = 8'h00
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic            hit_o,
    output logic [7:0]      q_o
);
    logic [7:0] data_reg;   // Stored byte
    logic [7:0] data_next;  // Next stored byte

    // Address match and next value
    assign hit_o     = (addr_i == ADDR);
    assign data_next = (wr_i && hit_o) ? wdata_i : data_reg;
    assign q_o       = data_reg;

    // Storage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_reg <= RESET;
        end else begin
            data_reg <= data_next;
        end
    end
endmodule

// ### verilog/fcr_pkg.sv
// Package: register offsets, field layout, mode codes and carriers
package fcr_pkg;
    // Register addresses in the register file
    localparam logic [7:0] FCR_ADDR_SECH = 8'hEC;
    localparam logic [7:0] FCR_ADDR_SECL = 8'hED;
    localparam logic [7:0] FCR_ADDR_KEY  = 8'hEE;
    localparam logic [7:0] FCR_ADDR_CTRL = 8'hEF;
    // Reset values
    localparam logic [7:0] FCR_RST_BYTE  = 8'h00;
    // Mode field position in control register
    localparam int         FCR_MODE_LSB  = 4;
    localparam int         FCR_MODE_MSB  = 7;
    localparam int         FCR_START_BIT = 0;
    // Unlock key
    localparam logic [7:0] FCR_KEY_OPEN  = 8'hA5;
    // Mode codes
    localparam logic [3:0] FCR_CODE_PROG = 4'h5;
    localparam logic [3:0] FCR_CODE_ERAS = 4'hA;
    localparam logic [3:0] FCR_CODE_LOCK = 4'h6;
    // Decoded operation
    typedef enum logic [1:0] {
        FCR_OP_NONE,
        FCR_OP_PROG,
        FCR_OP_ERASE,
        FCR_OP_HLOCK
    } fcr_op_t;
    // Register-file access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcr_req_t;
    // Command to the flash array sequencer
    typedef struct packed {
        fcr_op_t     op;
        logic        unlocked;
        logic        start;
        logic [15:0] sector;
    } fcr_cmd_t;
endpackage

// ### verilog/fcr_top.sv
// Flash control register front end: mode, sector pointer, unlock key
//
// Functional notes
// - Mode codes 0101/1010/0110 select program/erase/lock
// - Hard-lock code is a distinct protection mode
// - Bit 0 starts erase or hard-lock only; the stored mode is tested, so mode and bit 0 in one write can start program
// - Start bit launches, then clears itself
// - High register gives pointer bits 15..8
// - Low register gives pointer bits 7..0
// - Operations enabled only with key 10100101B
// - Any other key value disables operations
`timescale 1ns/1ps
module fcr_top (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire fcr_pkg::fcr_req_t req_i,
    output logic [7:0]            rdata_o,
    output logic                  rvalid_o,
    output fcr_pkg::fcr_cmd_t     cmd_o
);
    // Internal nets and flops
    logic       wr_w;          // Write strobe
    logic [7:0] sech_q;        // High sector byte
    logic [7:0] secl_q;        // Low sector byte
    logic [7:0] key_q;         // Unlock key byte
    logic       hit_sech;      // Address match, high sector
    logic       hit_secl;      // Address match, low sector
    logic       hit_key;       // Address match, key
    logic       hit_ctrl;      // Address match, control
    logic [3:0] mode_reg;      // Mode field
    logic [3:0] mode_next;     // Next mode field
    logic       start_reg;     // Start bit, self clearing
    logic       start_next;    // Next start bit
    logic       start_wr;      // Write of one to start bit
    logic       start_ok;      // Mode accepts a start
    logic       unlocked;      // Key matches, registered view
    logic [7:0] key_next;      // Key byte after this edge
    logic       unlock_next;   // Next unlock state
    logic       unlock_reg;    // Unlock state flop
    logic       is_prog;       // Next code is programming
    logic       is_erase;      // Next code is erase
    logic       is_lock;       // Next code is hard lock
    fcr_pkg::fcr_op_t op_next; // Next decoded operation
    fcr_pkg::fcr_op_t op_reg;  // Decoded operation flop
    logic [7:0] ctrl_view;     // Control register read image
    logic [7:0] rdata_next;    // Read mux result
    logic [7:0] rdata_reg;     // Registered read data
    logic       rvalid_reg;    // Read answer strobe
    // Strobe and read path nets
    logic       rd_w;          // Read strobe
    logic       ctrl_wr;       // Write at the control address
    logic [7:0] rdata_hold;    // Read data to store
    logic [7:0] rd_sech;       // High sector byte if addressed
    logic [7:0] rd_secl;       // Low sector byte if addressed
    logic [7:0] rd_key;        // Key byte if addressed
    logic [7:0] rd_ctrl;       // Control image if addressed

    // Field layout check: the read image and the mode slice
    // below assume a four-bit mode in the top nibble and the
    // start control in bit 0
    if (fcr_pkg::FCR_MODE_MSB != 7 ||
        fcr_pkg::FCR_MODE_LSB != 4 ||
        fcr_pkg::FCR_START_BIT != 0) begin : g_bad_layout
        $error("Control field layout not supported");
    end

    // Strobes taken straight from the request carrier
    assign wr_w = req_i.wr;
    assign rd_w = req_i.rd;

    // Sector pointer high byte
    // Byte register, written at its own address only
    fcr_byte_reg #(
        .ADDR  (fcr_pkg::FCR_ADDR_SECH),
        .RESET (fcr_pkg::FCR_RST_BYTE)
    ) u_sech (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .wr_i    (wr_w),
        .addr_i  (req_i.addr),
        .wdata_i (req_i.wdata),
        .hit_o   (hit_sech),
        .q_o     (sech_q)
    );

    // Sector pointer low byte
    // Pointer halves may be written in any order
    fcr_byte_reg #(
        .ADDR  (fcr_pkg::FCR_ADDR_SECL),
        .RESET (fcr_pkg::FCR_RST_BYTE)
    ) u_secl (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .wr_i    (wr_w),
        .addr_i  (req_i.addr),
        .wdata_i (req_i.wdata),
        .hit_o   (hit_secl),
        .q_o     (secl_q)
    );

    // Unlock key byte
    // Held as written; the key compare is done below
    fcr_byte_reg #(
        .ADDR  (fcr_pkg::FCR_ADDR_KEY),
        .RESET (fcr_pkg::FCR_RST_BYTE)
    ) u_key (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .wr_i    (wr_w),
        .addr_i  (req_i.addr),
        .wdata_i (req_i.wdata),
        .hit_o   (hit_key),
        .q_o     (key_q)
    );

    // Control byte kept here, not in a byte register,
    // because its fields act differently on a write
    assign hit_ctrl = (req_i.addr == fcr_pkg::FCR_ADDR_CTRL);
    assign ctrl_wr  = wr_w && hit_ctrl;

    // Mode written at control address, else held
    assign mode_next = ctrl_wr ?
        req_i.wdata[fcr_pkg::FCR_MODE_MSB:fcr_pkg::FCR_MODE_LSB] :
        mode_reg;

    // mode code compares
    // Decoded from the next mode so the op flop tracks mode_reg
    // and the command output comes straight from a flop
    assign is_prog  = (mode_next == fcr_pkg::FCR_CODE_PROG);
    assign is_erase = (mode_next == fcr_pkg::FCR_CODE_ERAS);
    assign is_lock  = (mode_next == fcr_pkg::FCR_CODE_LOCK);

    // unknown codes decode to no operation
    assign op_next = is_prog  ? fcr_pkg::FCR_OP_PROG  :
                     is_erase ? fcr_pkg::FCR_OP_ERASE :
                     is_lock  ? fcr_pkg::FCR_OP_HLOCK :
                                fcr_pkg::FCR_OP_NONE;

    // any other key locks them
    // Compared on the next key so the flop always matches key_q
    assign key_next    = (wr_w && hit_key) ? req_i.wdata : key_q;
    assign unlock_next = (key_next == fcr_pkg::FCR_KEY_OPEN);
    assign unlocked    = unlock_reg;

    // start only counts for erase or hard lock
    // no start under unknown or program mode
    // The stored operation is used, so the mode
    // must be written before the start bit.
    // A mode and start in one write would otherwise let a
    // stale mode launch the wrong operation.
    assign start_ok = (op_reg == fcr_pkg::FCR_OP_ERASE) ||
                      (op_reg == fcr_pkg::FCR_OP_HLOCK);

    // Write of one to the start bit
    assign start_wr   = ctrl_wr && req_i.wdata[fcr_pkg::FCR_START_BIT];
    // set for one cycle, then auto clear
    // Start also needs the unlock key in place
    assign start_next = start_wr && start_ok && unlocked;

    // Control register storage
    // Op and unlock flops follow mode and key one for one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Clear: no mode, no start, locked
            mode_reg   <= 4'h0;
            start_reg  <= 1'h0;
            op_reg     <= fcr_pkg::FCR_OP_NONE;
            unlock_reg <= 1'h0;
        end else begin
            // Capture next values
            mode_reg   <= mode_next;
            start_reg  <= start_next;
            op_reg     <= op_next;
            unlock_reg <= unlock_next;
        end
    end

    // Control read image, unused bits read zero
    // Start reads one only in its single pulse cycle
    assign ctrl_view = {mode_reg, 3'h0, start_reg};

    // Read data select, one term per register
    // Addresses are distinct, so at most one term is nonzero
    // and unmapped addresses read zero
    assign rd_sech    = hit_sech ? sech_q    : 8'h00;
    assign rd_secl    = hit_secl ? secl_q    : 8'h00;
    assign rd_key     = hit_key  ? key_q     : 8'h00;
    assign rd_ctrl    = hit_ctrl ? ctrl_view : 8'h00;
    assign rdata_next = rd_sech | rd_secl | rd_key | rd_ctrl;

    // Read data held until the next read
    assign rdata_hold = rd_w ? rdata_next : rdata_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Clear the read answer
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'h0;
        end else begin
            // Answer one cycle after the read strobe
            rdata_reg  <= rdata_hold;
            rvalid_reg <= rd_w;
        end
    end

    // Read answer ports
    assign rdata_o  = rdata_reg;
    assign rvalid_o = rvalid_reg;

    // low byte to pointer bottom
    // Command carrier built in one place, all fields from flops
    assign cmd_o = '{
        op:       op_reg,
        unlocked: unlocked,
        start:    start_reg,
        sector:   {sech_q, secl_q}
    };
endmodule
